/* File: logic/flash_ctrl_defines.svh */
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_ERASE_SETUP    8'h20
`define CMD_CONFIRM        8'hD0
`define CMD_WRITE_SETUP    8'h40
`define CMD_LOCK_SETUP     8'h60
`define CMD_LOCK_BLOCK     8'h01
`define CMD_LOCK_MASTER    8'hF1
`define CMD_READ_ARRAY     8'hFF
`define CMD_CLEAR_STATUS   8'h50
`define CMD_READ_STATUS    8'h70

// ****************************************
// status bit positions
// ****************************************
`define ST_READY           7
`define ST_ERASE_PAUSED    6
`define ST_ERASE_ERR       5
`define ST_PROG_ERR        4
`define ST_SUPPLY_LOW      3
`define ST_PROG_PAUSED     2
`define ST_PROTECT         1
`define ST_ERR_MASK        8'h3A
`define ST_KEEP_MASK       8'hFE

// ****************************************
// bus timing, in ns and in core clocks
// ****************************************
`define STROBE_NS          300
`define CLK_NS             100
`define STROBE_CYC         ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_EXTRA         8'h02

`endif

/* File: logic/flash_ctrl_pkg.sv */
`default_nettype none
package flash_ctrl_pkg;

  typedef enum logic [2:0] {
    OP_ERASE,
    OP_WRITE,
    OP_LOCK_BLOCK,
    OP_LOCK_MASTER,
    OP_CLEAR_LOCKS,
    OP_READ_ARRAY,
    OP_CLEAR_STATUS
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [17:0] addr;
    logic [7:0]  data;
  } request_t;

  typedef struct packed {
    logic [7:0]  status;
    logic        error;
    logic        improper;
  } result_t;

endpackage : flash_ctrl_pkg

`default_nettype wire

/* File: logic/flash_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"

// Functional notes
// RQ1 - status bit 7 high means engine ready, low means busy.
// RQ2 - ignore status bits 6..0 until bit 7 reads ready.
// RQ3 - bit 6 reports block erase suspended.
// RQ4 - bit 5 reports erase or clear-locks failure.
// RQ5 - bit 4 reports byte write or lock-set failure.
// RQ6 - bit 3 reports low program supply and aborted operation.
// RQ7 - supply bit only updated by an operation sampling the supply.
// RQ8 - bit 2 reports byte write suspended.
// RQ9 - bit 1 reports operation blocked by lock bits or reset level.
// RQ10 - protection bit only evaluated during program, erase, lock operations.
// RQ11 - mask reserved status bit 0 when polling.
// RQ12 - bits 5 and 4 both set mean improper command sequence.
// RQ13 - block erase is 20H then D0H at block address.
// RQ14 - byte write is 40H then data at the same address.
// RQ15 - lock set is 60H then 01H block or F1H master.
// RQ16 - clear all locks is 60H then D0H, address ignored.
// RQ17 - write FFH afterwards to return to array reads.
// RQ18 - completion detected by ready/busy pin or status bit 7.
// RQ19 - full error check after each operation or after a series.
// RQ20 - ready/busy goes low on accepted command, high when done.
// RQ21 - byte write suspend sets bits 7 and 2, ready/busy high.
// RQ22 - master lock without high voltage sets bits 1 and 4.
// RQ23 - after reset status shows ready, no errors, array-read mode.
// RQ24 - error bits stay set until the host clears status.
module flash_ctrl #(
  parameter int STROBE_CYCLES = `STROBE_CYC
) (
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_n_i,
  // user request
  input  wire logic                       req_valid_i,
  input  wire flash_ctrl_pkg::request_t   req_i,
  output logic                            req_ready_o,
  output logic                            done_o,
  output flash_ctrl_pkg::result_t         result_o,
  // flash pins
  output logic [17:0]                     addr_o,
  output logic [7:0]                      dq_o,
  output logic                            dq_oe_o,
  input  wire logic [7:0]                 dq_i,
  output logic                            chip_en_n_o,
  output logic                            write_en_n_o,
  output logic                            out_en_n_o,
  input  wire logic                       ready_busy_n_i
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] dq_s1_q, dq_s2_q;
  logic       rb_s1_q, rb_s2_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n_i;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_W1, S_GAP1, S_W2, S_GAP2, S_WAIT_BUSY, S_POLL, S_SAMPLE, S_DONE
  } state_t;

  state_t                    st_q, st_d;
  logic [7:0]                cnt_q, cnt_d;
  logic [7:0]                strobe_len_q, strobe_len_d;
  logic [7:0]                c1_q, c1_d, c2_q, c2_d;
  logic                      two_q, two_d, busy_op_q, busy_op_d;
  logic [17:0]               addr_q, addr_d;
  logic [7:0]                dq_q, dq_d;
  logic                      oe_q, oe_d, ce_n_q, ce_n_d, we_n_q, we_n_d, rd_n_q, rd_n_d;
  logic                      rdy_q, rdy_d, done_q, done_d;
  flash_ctrl_pkg::result_t   res_q, res_d;

  function automatic logic [15:0] encode(input flash_ctrl_pkg::request_t r);
    unique case (r.op)
      flash_ctrl_pkg::OP_ERASE:        encode = {`CMD_ERASE_SETUP, `CMD_CONFIRM};  // see RQ13
      flash_ctrl_pkg::OP_WRITE:        encode = {`CMD_WRITE_SETUP, r.data};        // see RQ14
      flash_ctrl_pkg::OP_LOCK_BLOCK:   encode = {`CMD_LOCK_SETUP, `CMD_LOCK_BLOCK}; // see RQ15
      flash_ctrl_pkg::OP_LOCK_MASTER:  encode = {`CMD_LOCK_SETUP, `CMD_LOCK_MASTER}; // see RQ15
      flash_ctrl_pkg::OP_CLEAR_LOCKS:  encode = {`CMD_LOCK_SETUP, `CMD_CONFIRM};   // see RQ16
      flash_ctrl_pkg::OP_READ_ARRAY:   encode = {`CMD_READ_ARRAY, 8'h00};          // see RQ17
      flash_ctrl_pkg::OP_CLEAR_STATUS: encode = {`CMD_CLEAR_STATUS, 8'h00};        // see RQ24
      default:                         encode = {`CMD_READ_ARRAY, 8'h00};
    endcase
  endfunction

  function automatic logic two_cycle(input flash_ctrl_pkg::op_t op);
    two_cycle = (op != flash_ctrl_pkg::OP_READ_ARRAY) && (op != flash_ctrl_pkg::OP_CLEAR_STATUS);
  endfunction

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    strobe_len_d = we_n_q ? 8'h00 : strobe_len_q + 8'h01;
    c1_d      = c1_q;
    c2_d      = c2_q;
    two_d     = two_q;
    busy_op_d = busy_op_q;
    addr_d    = addr_q;
    dq_d      = dq_q;
    oe_d      = oe_q;
    ce_n_d    = ce_n_q;
    we_n_d    = we_n_q;
    rd_n_d    = rd_n_q;
    rdy_d     = rdy_q;
    done_d    = 1'b0;
    res_d     = res_q;
    unique case (st_q)
      S_IDLE: begin
        if (req_valid_i) begin
          {c1_d, c2_d} = encode(req_i);
          two_d     = two_cycle(req_i.op);
          busy_op_d = two_cycle(req_i.op);
          addr_d    = req_i.addr;
          dq_d      = c1_d;
          oe_d      = 1'b1;
          ce_n_d    = 1'b0;
          we_n_d    = 1'b0;
          rdy_d     = 1'b0;
          cnt_d     = 8'(STROBE_CYCLES);
          st_d      = S_W1;
        end
      end
      S_W1, S_W2: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          cnt_d  = 8'(STROBE_CYCLES);
          st_d   = (st_q == S_W1) ? S_GAP1 : S_GAP2;
        end
      end
      S_GAP1: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          if (two_q) begin
            dq_d   = c2_q;
            ce_n_d = 1'b0;
            we_n_d = 1'b0;
            cnt_d  = 8'(STROBE_CYCLES);
            st_d   = S_W2;
          end else begin
            oe_d   = 1'b0;
            st_d   = S_DONE;
          end
        end
      end
      S_GAP2: begin
        oe_d  = 1'b0;
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          st_d = S_WAIT_BUSY;
        end
      end
      S_WAIT_BUSY: begin
        // device pulls ready_busy low once command accepted
        if (!rb_s2_q || busy_op_q) begin
          st_d = S_POLL;
        end
      end
      S_POLL: begin
        if (rb_s2_q) begin                                        // see RQ18
          ce_n_d = 1'b0;
          rd_n_d = 1'b0;
          cnt_d  = 8'(STROBE_CYCLES) + `SYNC_EXTRA;
          st_d   = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          ce_n_d = 1'b1;
          rd_n_d = 1'b1;
          if (dq_s2_q[`ST_READY]) begin                           // see RQ1
            res_d.status   = dq_s2_q & `ST_KEEP_MASK;             // see RQ11
            res_d.error    = |(dq_s2_q & `ST_ERR_MASK);           // see RQ2, RQ19
            res_d.improper = dq_s2_q[`ST_ERASE_ERR] & dq_s2_q[`ST_PROG_ERR]; // see RQ12
            st_d           = S_DONE;
          end else begin
            st_d = S_POLL;
          end
        end
      end
      S_DONE: begin
        done_d = 1'b1;
        rdy_d  = 1'b1;
        st_d   = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q      <= S_IDLE;
      cnt_q     <= 8'h00;
      strobe_len_q <= 8'h00;
      c1_q      <= 8'h00;
      c2_q      <= 8'h00;
      two_q     <= 1'b0;
      busy_op_q <= 1'b0;
      addr_q    <= 18'h00000;
      dq_q      <= 8'h00;
      oe_q      <= 1'b0;
      ce_n_q    <= 1'b1;
      we_n_q    <= 1'b1;
      rd_n_q    <= 1'b1;
      rdy_q     <= 1'b1;
      done_q    <= 1'b0;
      res_q     <= '0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      strobe_len_q <= strobe_len_d;
      c1_q      <= c1_d;
      c2_q      <= c2_d;
      two_q     <= two_d;
      busy_op_q <= busy_op_d;
      addr_q    <= addr_d;
      dq_q      <= dq_d;
      oe_q      <= oe_d;
      ce_n_q    <= ce_n_d;
      we_n_q    <= we_n_d;
      rd_n_q    <= rd_n_d;
      rdy_q     <= rdy_d;
      done_q    <= done_d;
      res_q     <= res_d;
    end
  end

  assign req_ready_o  = rdy_q;
  assign done_o       = done_q;
  assign result_o     = res_q;
  assign addr_o       = addr_q;
  assign dq_o         = dq_q;
  assign dq_oe_o      = oe_q;
  assign chip_en_n_o  = ce_n_q;
  assign write_en_n_o = we_n_q;
  assign out_en_n_o   = rd_n_q;

  // ****************************************
  // checks
  // ****************************************
  sequence setup_strobe_s;
    $fell(write_en_n_o) && dq_oe_o;
  endsequence

  write_pair_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ13
    (st_q == S_GAP1 && two_q && cnt_q == 8'h01) |=> (!write_en_n_o && dq_o == c2_q))
    else $error("confirm write missing");

  strobe_data_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ14
    setup_strobe_s |-> (dq_o == c1_q || dq_o == c2_q))
    else $error("strobe without command data");

  poll_wait_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ18
    (st_q == S_POLL && !rb_s2_q) |=> (out_en_n_o))
    else $error("status read while busy");

  done_ready_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ1
    (done_o && busy_op_q) |-> result_o.status[`ST_READY])
    else $error("done without ready status");

  no_drive_read_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ17
    !out_en_n_o |-> !dq_oe_o)
    else $error("bus contention on read");

  improper_flag_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ12
    done_o |-> (result_o.improper == (result_o.status[`ST_ERASE_ERR] && result_o.status[`ST_PROG_ERR])))
    else $error("improper flag mismatch");

  reserved_mask_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ11
    done_o |-> !result_o.status[0])
    else $error("reserved bit passed");

  strobe_width_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see RQ15
    $rose(write_en_n_o) |-> (strobe_len_q == 8'(STROBE_CYCLES)))
    else $error("write strobe width wrong");

endmodule : flash_ctrl

`default_nettype wire

/* File: dv/flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// flash device model
// ****
module flash_model #(
  parameter int BUSY = 20
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        supply_low_i,
  input  wire logic        high_volt_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        dq_oe_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  output logic [7:0]       dq_o,
  output logic             ready_busy_n_o
);
  logic [7:0]  st_q, lat_d, setup_q, last_q, e;
  logic [7:0]  mem [16];
  logic [17:0] lat_a, setup_a;
  logic [3:0]  lock_q = 4'h0;
  logic        wr_q, stat_q, lk, bad;
  logic        master_q = 1'b0;
  int          busy_q;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  assign ready_busy_n_o = (busy_q == 0);
  assign dq_o = (!ce_n_i && !oe_n_i) ? (stat_q ? st_q : mem[addr_i[3:0]]) : ~last_q;
  task automatic cmd(input logic [7:0] d, input logic [17:0] a);
    lk = lock_q[a[17:16]] && !high_volt_i;
    bad = master_q && !high_volt_i;
    e = 8'h00;
    if (setup_q == 8'h00) begin
      stat_q <= (d != 8'hFF);
      if (d == 8'h50) st_q[5:1] <= 5'h00;
      if (d == 8'h20 || d == 8'h40 || d == 8'h60) begin
        setup_q <= d;
        setup_a <= a;
      end
    end else begin
      setup_q <= 8'h00;
      if (setup_q == 8'h20 && d == 8'hD0 && a[17:16] == setup_a[17:16])
        e = supply_low_i ? 8'h28 : lk ? 8'h22 : 8'h00;
      else if (setup_q == 8'h40 && a == setup_a) begin
        e = supply_low_i ? 8'h18 : lk ? 8'h12 : 8'h00;
        if (e == 8'h00) mem[a[3:0]] <= d;
      end else if (setup_q == 8'h60 && d == 8'h01) begin
        e = supply_low_i ? 8'h18 : bad ? 8'h12 : 8'h00;
        if (e == 8'h00) lock_q[a[17:16]] <= 1'b1;
      end else if (setup_q == 8'h60 && d == 8'hF1) begin
        e = supply_low_i ? 8'h18 : !high_volt_i ? 8'h12 : 8'h00;
        if (e == 8'h00) master_q <= 1'b1;
      end else if (setup_q == 8'h60 && d == 8'hD0) begin
        e = supply_low_i ? 8'h28 : bad ? 8'h22 : 8'h00;
        if (e == 8'h00) lock_q <= 4'h0;
      end else
        e = 8'h30;
      // supply and locks sampled here only, errors sticky, no suspend
      st_q <= {2'b00, st_q[5:0] | e[5:0]};
      busy_q <= BUSY;
    end
  endtask
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= 8'h80;
      stat_q <= 1'b0;
      setup_q <= 8'h00;
      wr_q <= 1'b0;
      busy_q <= 0;
      last_q <= 8'h00;
    end else begin
      if (busy_q == 1) st_q[7] <= 1'b1;
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (!ce_n_i && !oe_n_i) last_q <= dq_o;
      if (!ce_n_i && !we_n_i && dq_oe_i) begin
        wr_q <= 1'b1;
        lat_d <= dq_i;
        lat_a <= addr_i;
      end else if (wr_q) begin
        wr_q <= 1'b0;
        cmd(lat_d, lat_a);
      end
    end
  end
endmodule : flash_model
`default_nettype wire

/* File: dv/flash_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module flash_ctrl_tb;
  typedef struct {
    flash_ctrl_pkg::op_t op;
    logic [17:0]         a;
    logic [7:0]          d;
    logic [1:0]          c;
    logic [7:0]          st;
  } row_t;
  logic                     core_clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     req_valid = 1'b0;
  logic                     supply_low = 1'b0;
  logic                     high_volt = 1'b0;
  flash_ctrl_pkg::request_t req = '0;
  flash_ctrl_pkg::result_t  res;
  logic [17:0]              addr;
  logic [7:0]               dq_out, dq_in;
  logic                     ready, done, dq_oe, ce_n, we_n, oe_n, rb_n;
  int                       num_errors = 0;
  int                       cmp_count = 0;
  int                       lat;
  row_t rows [13] = '{
    '{flash_ctrl_pkg::OP_LOCK_BLOCK, 18'h10000, 8'h00, 2'h0, 8'h80},
    '{flash_ctrl_pkg::OP_ERASE, 18'h10004, 8'h00, 2'h0, 8'hA2},
    '{flash_ctrl_pkg::OP_WRITE, 18'h10005, 8'h5A, 2'h0, 8'h92},
    '{flash_ctrl_pkg::OP_WRITE, 18'h10005, 8'h5A, 2'h1, 8'h80},
    '{flash_ctrl_pkg::OP_ERASE, 18'h00003, 8'h00, 2'h2, 8'hA8},
    '{flash_ctrl_pkg::OP_WRITE, 18'h00002, 8'hC3, 2'h2, 8'h98},
    '{flash_ctrl_pkg::OP_LOCK_MASTER, 18'h0, 8'h00, 2'h0, 8'h92},
    '{flash_ctrl_pkg::OP_LOCK_MASTER, 18'h0, 8'h00, 2'h1, 8'h80},
    '{flash_ctrl_pkg::OP_LOCK_BLOCK, 18'h20000, 8'h00, 2'h0, 8'h92},
    '{flash_ctrl_pkg::OP_CLEAR_LOCKS, 18'h0, 8'h00, 2'h0, 8'hA2},
    '{flash_ctrl_pkg::OP_CLEAR_LOCKS, 18'h0, 8'h00, 2'h3, 8'hA8},
    '{flash_ctrl_pkg::OP_CLEAR_LOCKS, 18'h0, 8'h00, 2'h1, 8'h80},
    '{flash_ctrl_pkg::OP_WRITE, 18'h10007, 8'h3C, 2'h0, 8'h80}};
  always #50 core_clk = ~core_clk;
  flash_ctrl #(.STROBE_CYCLES(1)) flash_ctrl_i (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(ready), .done_o(done), .result_o(res), .addr_o(addr), .dq_o(dq_out),
    .dq_oe_o(dq_oe), .dq_i(dq_in), .chip_en_n_o(ce_n), .write_en_n_o(we_n),
    .out_en_n_o(oe_n), .ready_busy_n_i(rb_n));
  flash_model #(.BUSY(20)) flash_model_i (
    .clk_i(core_clk), .rst_n_i(reset_n), .supply_low_i(supply_low), .high_volt_i(high_volt),
    .addr_i(addr), .dq_i(dq_out), .dq_oe_i(dq_oe), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .dq_o(dq_in), .ready_busy_n_o(rb_n));
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_op(input flash_ctrl_pkg::op_t op, input logic [17:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{op, a, d};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 3000) begin
      @(negedge core_clk);
      lat++;
    end
    if (lat >= 3000) begin
      num_errors++;
      $display("ERROR %0t no completion", $time);
      end_sim();
    end
  endtask : do_op
  task automatic pulse_reset;
    reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    check({ready, ce_n, we_n, oe_n, dq_oe, done}, 8'h3C);
    check(res.status, 8'h00);
    reset_n = 1'b1;
  endtask : pulse_reset
  initial begin
    pulse_reset();
    foreach (rows[i]) begin
      do_op(flash_ctrl_pkg::OP_CLEAR_STATUS, 18'h0, 8'h00);
      {supply_low, high_volt} = rows[i].c;
      do_op(rows[i].op, rows[i].a, rows[i].d);
      check(res.status, rows[i].st);
      check(res.error, |(rows[i].st & 8'h3A));
      check(res.improper, rows[i].st[5] & rows[i].st[4]);
      check(lat > 20, 1'b1);
    end
    check(flash_model_i.mem[5], 8'h5A);
    check(flash_model_i.mem[2], 8'hFF);
    supply_low = 1'b1;
    do_op(flash_ctrl_pkg::OP_ERASE, 18'h0, 8'h00);
    supply_low = 1'b0;
    do_op(flash_ctrl_pkg::OP_ERASE, 18'h0, 8'h00);
    check(res.status, 8'hA8);
    do_op(flash_ctrl_pkg::OP_READ_ARRAY, 18'h0, 8'h00);
    check(flash_model_i.stat_q, 8'h00);
    req = '{flash_ctrl_pkg::OP_ERASE, 18'h0, 8'h00};
    req_valid = 1'b1;
    repeat (6) @(negedge core_clk);
    req_valid = 1'b0;
    pulse_reset();
    do_op(flash_ctrl_pkg::OP_ERASE, 18'h0, 8'h00);
    check(res.status, 8'h80);
    end_sim();
  end
endmodule : flash_ctrl_tb
`default_nettype wire
